// ===== src/fl_pkg.sv
`default_nettype none
package fl_pkg;

  // ----------------------------------------------------------------
  // clock and conversion
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;

  // whole cycles covering a time, never fewer than one
  function automatic int ceil_cyc(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W       = 16;
  localparam int DATA_W       = 8;
  localparam int SECTOR_BYTES = 128;
  localparam int SECTOR_COUNT = 512;
  localparam int BYTE_LSB_W   = 7;
  localparam int POLL_BIT     = 7;
  localparam int TOGGLE_BIT   = 6;

  // ----------------------------------------------------------------
  // bus timing
  // ----------------------------------------------------------------
  localparam int STROBE_NS   = 50;
  localparam int ACCESS_NS   = 120;
  localparam int RECOVER_NS  = 50;
  localparam int STROBE_CYC  = ceil_cyc(STROBE_NS);
  localparam int ACCESS_CYC  = ceil_cyc(ACCESS_NS);
  localparam int RECOVER_CYC = ceil_cyc(RECOVER_NS);

  // ----------------------------------------------------------------
  // long times
  // ----------------------------------------------------------------
  localparam int LOAD_GAP_US    = 150;
  localparam int LOAD_GAP_CYC   = (LOAD_GAP_US * 1000) / CLK_PERIOD_NS;
  localparam int STARVE_CYC     = LOAD_GAP_CYC / 2;
  localparam int WINDOW_CYC     = LOAD_GAP_CYC + 1;
  localparam int PROG_CYCLE_MS  = 20;
  localparam int PROG_CYCLE_CYC = (PROG_CYCLE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int POWER_ON_MS    = 10;
  localparam int POWER_ON_CYC   = (POWER_ON_MS * 1000000) / CLK_PERIOD_NS;
  localparam int TMR_W          = 22;

  // ----------------------------------------------------------------
  // commands, states, carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FL_OP_READ = 2'b00,
    FL_OP_PROG = 2'b01
  } fl_op_t;

  typedef enum logic [2:0] {
    FL_PWRUP   = 3'b000,
    FL_IDLE    = 3'b001,
    FL_RD      = 3'b010,
    FL_CMD     = 3'b011,
    FL_LOADGET = 3'b100,
    FL_LOAD    = 3'b101,
    FL_WINDOW  = 3'b110,
    FL_POLL    = 3'b111
  } fl_state_t;

  typedef enum logic [1:0] {
    FL_PH_SET  = 2'b00,
    FL_PH_LOW  = 2'b01,
    FL_PH_HIGH = 2'b10
  } fl_phase_t;

  typedef struct packed {
    fl_op_t              op;
    logic [ADDR_W-1:0]   addr;
  } fl_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0]   addr;
    logic                ce_n;
    logic                oe_n;
    logic                we_n;
    logic [DATA_W-1:0]   dq;
    logic                dq_oe;
  } fl_pins_t;

  localparam fl_pins_t PINS_IDLE = '{addr: 16'h0000, ce_n: 1'b1,
    oe_n: 1'b1, we_n: 1'b1, dq: 8'hFF, dq_oe: 1'b0};

endpackage
`default_nettype wire

// ===== src/fl_timer.sv
`default_nettype none
module fl_timer #(
  parameter int W = 22
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  // control
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  // status
  output logic              done_o
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // ----------------------------------------------------------------
  // down counter, holds at zero
  // ----------------------------------------------------------------
  always_comb begin
    if (load_i) begin
      next_count = value_i;
    end else if (count != '0) begin
      next_count = count - W'(1);
    end else begin
      next_count = count;
    end
  end

  // register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign done_o = (count == '0);

endmodule // fl_timer
`default_nettype wire

// ===== src/fl_flash_host.sv
// What this block does
// - host loads up to 128 bytes per sector, fewer if the source starves
// - host writes three command bytes first
// - every program starts with command bytes
// - write strobe with select low, output enable high
// - next load begins within 150 us
// - host keeps sector address on every load
`default_nettype none
module fl_flash_host #(
  parameter int                        PROG_CYCLE_CYCLES =
    fl_pkg::PROG_CYCLE_CYC,
  parameter int                        POWER_ON_CYCLES   =
    fl_pkg::POWER_ON_CYC,
  parameter int                        STARVE_CYCLES     = fl_pkg::STARVE_CYC,
  parameter int                        WINDOW_CYCLES     = fl_pkg::WINDOW_CYC,
  parameter int                        LOAD_GAP_CYCLES   =
    fl_pkg::LOAD_GAP_CYC,
  parameter logic [fl_pkg::ADDR_W-1:0] CMD_ADDR0 = 16'h1111,
  parameter logic [fl_pkg::ADDR_W-1:0] CMD_ADDR1 = 16'h2222,
  parameter logic [fl_pkg::ADDR_W-1:0] CMD_ADDR2 = 16'h3333,
  parameter logic [fl_pkg::DATA_W-1:0] CMD_DATA0 = 8'hA1,
  parameter logic [fl_pkg::DATA_W-1:0] CMD_DATA1 = 8'hB2,
  parameter logic [fl_pkg::DATA_W-1:0] CMD_DATA2 = 8'hC3
) (
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      resetn_i,
  // user request
  input  wire logic                      start_i,
  input  wire fl_pkg::fl_req_t           req_i,
  output logic                           ready_o,
  // program byte stream
  input  wire logic                      wr_valid_i,
  input  wire logic [fl_pkg::DATA_W-1:0] wr_data_i,
  output logic                           wr_ready_o,
  // results
  output logic [fl_pkg::DATA_W-1:0]      rd_data_o,
  output logic                           rd_valid_o,
  output logic                           done_o,
  output logic                           err_o,
  // flash pins
  output fl_pkg::fl_pins_t               flash_o,
  input  wire logic [fl_pkg::DATA_W-1:0] data_i
);

  localparam int            TW        = fl_pkg::TMR_W;
  localparam logic [TW-1:0] T_STROBE  = TW'(fl_pkg::STROBE_CYC);
  localparam logic [TW-1:0] T_ACCESS  = TW'(fl_pkg::ACCESS_CYC);
  localparam logic [TW-1:0] T_RECOVER = TW'(fl_pkg::RECOVER_CYC);
  localparam logic [TW-1:0] T_STARVE  = TW'(STARVE_CYCLES);
  localparam logic [TW-1:0] T_WINDOW  = TW'(WINDOW_CYCLES);
  localparam logic [TW-1:0] T_PROG    = TW'(PROG_CYCLE_CYCLES);
  localparam logic [TW-1:0] T_PWR     = TW'(POWER_ON_CYCLES);

  // command address and data by step
  function automatic logic [fl_pkg::ADDR_W+fl_pkg::DATA_W-1:0] cmd(
    input logic [1:0] s);
    case (s)
      2'b00:   cmd = {CMD_ADDR0, CMD_DATA0};
      2'b01:   cmd = {CMD_ADDR1, CMD_DATA1};
      default: cmd = {CMD_ADDR2, CMD_DATA2};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fl_pkg::fl_state_t         state, next_state;
  fl_pkg::fl_phase_t         ph, next_ph;
  fl_pkg::fl_pins_t          pins, next_pins;
  logic [1:0]                step, next_step;
  logic [7:0]                idx, next_idx;
  logic [8:0]                sector, next_sector;
  logic [fl_pkg::DATA_W-1:0] last_data, next_last_data;
  logic                      prev6, next_prev6;
  logic                      have_prev, next_have_prev;
  logic                      ready, next_ready;
  logic                      wr_ready, next_wr_ready;
  logic [fl_pkg::DATA_W-1:0] rd_data, next_rd_data;
  logic                      rd_valid, next_rd_valid;
  logic                      done, next_done;
  logic                      err, next_err;
  logic                      s_load, l_load, s_done, l_done;
  logic [fl_pkg::TMR_W-1:0]  s_val, l_val;

  // short timer paces strobes, long timer paces windows
  fl_timer #(.W(fl_pkg::TMR_W)) u_short (
    .clk_i(clk_i), .resetn_i(resetn_i),
    .load_i(s_load), .value_i(s_val), .done_o(s_done));
  fl_timer #(.W(fl_pkg::TMR_W)) u_long (
    .clk_i(clk_i), .resetn_i(resetn_i),
    .load_i(l_load), .value_i(l_val), .done_o(l_done));

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_ph        = ph;
    next_pins      = pins;
    next_step      = step;
    next_idx       = idx;
    next_sector    = sector;
    next_last_data = last_data;
    next_prev6     = prev6;
    next_have_prev = have_prev;
    next_wr_ready  = 1'b0;
    next_rd_data   = rd_data;
    next_rd_valid  = 1'b0;
    next_done      = 1'b0;
    next_err       = 1'b0;
    s_load         = 1'b0;
    s_val          = T_STROBE;
    l_load         = 1'b0;
    l_val          = T_WINDOW;
    case (state)
      fl_pkg::FL_PWRUP: begin
        // arm the power-on wait once after reset, then sit it out
        if (ph == fl_pkg::FL_PH_SET) begin
          l_load  = 1'b1;
          l_val   = T_PWR;
          next_ph = fl_pkg::FL_PH_LOW;
        end else if (l_done) begin
          next_state = fl_pkg::FL_IDLE;
        end
      end
      fl_pkg::FL_IDLE: begin
        if (start_i && ready) begin
          next_ph = fl_pkg::FL_PH_SET;
          if (req_i.op == fl_pkg::FL_OP_PROG) begin
            // unlock sequence first, every time
            next_state = fl_pkg::FL_CMD;
            next_step  = 2'b00;
            next_idx   = 8'h00;
            next_sector = req_i.addr[15:7];
            {next_pins.addr, next_pins.dq} = cmd(2'b00);
            next_pins.dq_oe = 1'b1;
          end else begin
            next_state     = fl_pkg::FL_RD;
            next_pins.addr = req_i.addr;
          end
        end
      end
      fl_pkg::FL_CMD, fl_pkg::FL_LOAD: begin
        case (ph)
          fl_pkg::FL_PH_SET: begin
            // select and write low together, output enable high
            next_pins.ce_n = 1'b0;
            next_pins.we_n = 1'b0;
            next_pins.oe_n = 1'b1;
            s_load  = 1'b1;
            next_ph = fl_pkg::FL_PH_LOW;
          end
          fl_pkg::FL_PH_LOW: begin
            if (s_done) begin
              next_pins.ce_n = 1'b1;
              next_pins.we_n = 1'b1;
              s_load  = 1'b1;
              s_val   = T_RECOVER;
              next_ph = fl_pkg::FL_PH_HIGH;
              // gap to the next load counts from this rise
              if (state == fl_pkg::FL_LOAD) begin
                l_load = 1'b1;
                l_val  = T_STARVE;
              end
            end
          end
          default: begin
            if (s_done) begin
              next_pins.dq_oe = 1'b0;
              if (state == fl_pkg::FL_CMD && step != 2'b10) begin
                next_step = step + 2'b01;
                {next_pins.addr, next_pins.dq} = cmd(step + 2'b01);
                next_pins.dq_oe = 1'b1;
                next_ph = fl_pkg::FL_PH_SET;
              end else if (idx == 8'(fl_pkg::SECTOR_BYTES)) begin
                // whole sector in; let the load window lapse
                next_state = fl_pkg::FL_WINDOW;
                l_load     = 1'b1;
              end else begin
                next_state    = fl_pkg::FL_LOADGET;
                next_wr_ready = 1'b1;
                if (state == fl_pkg::FL_CMD) begin
                  l_load = 1'b1;
                  l_val  = T_STARVE;
                end
              end
            end
          end
        endcase
      end
      fl_pkg::FL_LOADGET: begin
        if (wr_valid_i && wr_ready) begin
          // sector bits fixed, byte index walks the sector
          next_pins.addr  = {sector, idx[6:0]};
          next_pins.dq    = wr_data_i;
          next_pins.dq_oe = 1'b1;
          next_last_data  = wr_data_i;
          next_idx        = idx + 8'h01;
          next_state      = fl_pkg::FL_LOAD;
          next_ph         = fl_pkg::FL_PH_SET;
        end else if (l_done) begin
          // source starved: device programs a partial sector
          next_err   = 1'b1;
          next_state = fl_pkg::FL_WINDOW;
          l_load     = 1'b1;
        end else begin
          next_wr_ready = 1'b1;
        end
      end
      fl_pkg::FL_WINDOW: begin
        if (l_done) begin
          next_state     = fl_pkg::FL_POLL;
          next_ph        = fl_pkg::FL_PH_SET;
          next_have_prev = 1'b0;
          l_load         = 1'b1;
          l_val          = T_PROG;
        end
      end
      fl_pkg::FL_POLL, fl_pkg::FL_RD: begin
        case (ph)
          fl_pkg::FL_PH_SET: begin
            next_pins.ce_n = 1'b0;
            next_pins.oe_n = 1'b0;
            s_load  = 1'b1;
            s_val   = T_ACCESS;
            next_ph = fl_pkg::FL_PH_LOW;
          end
          fl_pkg::FL_PH_LOW: begin
            if (s_done) begin
              next_pins.ce_n = 1'b1;
              next_pins.oe_n = 1'b1;
              s_load  = 1'b1;
              s_val   = T_RECOVER;
              next_ph = fl_pkg::FL_PH_HIGH;
              if (state == fl_pkg::FL_RD) begin
                next_rd_data  = data_i;
                next_rd_valid = 1'b1;
              end else if (have_prev
                  && prev6 == data_i[fl_pkg::TOGGLE_BIT]
                  && data_i[fl_pkg::POLL_BIT]
                     == last_data[fl_pkg::POLL_BIT]) begin
                // toggle stopped and top bit true: finished
                next_done  = 1'b1;
                next_state = fl_pkg::FL_RD;
              end else begin
                next_prev6     = data_i[fl_pkg::TOGGLE_BIT];
                next_have_prev = 1'b1;
              end
            end
          end
          default: begin
            if (s_done) begin
              if (state == fl_pkg::FL_RD) begin
                next_state = fl_pkg::FL_IDLE;
              end else if (l_done) begin
                next_err   = 1'b1;
                next_state = fl_pkg::FL_IDLE;
              end else begin
                next_ph = fl_pkg::FL_PH_SET;
              end
            end
          end
        endcase
      end
      default: begin
        next_state = fl_pkg::FL_IDLE;
      end
    endcase
    next_ready = (next_state == fl_pkg::FL_IDLE) && !(start_i && ready);
  end

  // register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state     <= fl_pkg::FL_PWRUP;
      ph        <= fl_pkg::FL_PH_SET;
      pins      <= fl_pkg::PINS_IDLE;
      step      <= 2'b00;
      idx       <= 8'h00;
      sector    <= 9'h000;
      last_data <= 8'hFF;
      prev6     <= 1'b0;
      have_prev <= 1'b0;
      ready     <= 1'b0;
      wr_ready  <= 1'b0;
      rd_data   <= 8'h00;
      rd_valid  <= 1'b0;
      done      <= 1'b0;
      err       <= 1'b0;
    end else begin
      state     <= next_state;
      ph        <= next_ph;
      pins      <= next_pins;
      step      <= next_step;
      idx       <= next_idx;
      sector    <= next_sector;
      last_data <= next_last_data;
      prev6     <= next_prev6;
      have_prev <= next_have_prev;
      ready     <= next_ready;
      wr_ready  <= next_wr_ready;
      rd_data   <= next_rd_data;
      rd_valid  <= next_rd_valid;
      done      <= next_done;
      err       <= next_err;
    end
  end

  // outputs
  assign ready_o    = ready;
  assign wr_ready_o = wr_ready;
  assign rd_data_o  = rd_data;
  assign rd_valid_o = rd_valid;
  assign done_o     = done;
  assign err_o      = err;
  assign flash_o    = pins;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [15:0] gap_cnt, next_gap_cnt;
  logic [23:0] poll_cnt, next_poll_cnt;

  // helper counts: cycles since strobe rose, cycles spent polling
  always_comb begin
    next_gap_cnt  = gap_cnt;
    next_poll_cnt = 24'h000000;
    if (!pins.we_n) begin
      next_gap_cnt = 16'h0000;
    end else if (gap_cnt != 16'hFFFF) begin
      next_gap_cnt = gap_cnt + 16'h0001;
    end
    if (state == fl_pkg::FL_POLL) begin
      next_poll_cnt = poll_cnt + 24'h000001;
    end
  end

  // register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      gap_cnt  <= 16'h0000;
      poll_cnt <= 24'h000000;
    end else begin
      gap_cnt  <= next_gap_cnt;
      poll_cnt <= next_poll_cnt;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  write_oe_high_a: assert property (!pins.we_n |-> pins.oe_n)
    else $error("write strobe with output enable low");
  write_ce_low_a: assert property (!pins.we_n |-> !pins.ce_n)
    else $error("write strobe without chip select");
  cmd_bytes_a: assert property (state == fl_pkg::FL_CMD
      && $fell(pins.we_n) |-> {pins.addr, pins.dq} == cmd(step) && pins.dq_oe)
    else $error("wrong command byte");
  sector_hold_a: assert property (state == fl_pkg::FL_LOAD
      && $fell(pins.we_n) |-> pins.addr[15:7] == sector)
    else $error("sector address moved");
  full_sector_a: assert property ($rose(state == fl_pkg::FL_WINDOW)
      && !err |-> idx == 8'(fl_pkg::SECTOR_BYTES))
    else $error("sector not fully loaded");
  load_gap_a: assert property (state == fl_pkg::FL_LOAD
      && $fell(pins.we_n) && idx != 8'h01 |-> $past(gap_cnt) < LOAD_GAP_CYCLES)
    else $error("load gap too long");
  cmd_first_a: assert property ($rose(state == fl_pkg::FL_LOADGET)
      && idx == 8'h00 |-> $past(state) == fl_pkg::FL_CMD && step == 2'b10)
    else $error("load without command sequence");
  poll_bound_a: assert property (state == fl_pkg::FL_POLL
      |-> poll_cnt <= PROG_CYCLE_CYCLES + 2 * fl_pkg::ACCESS_CYC + 8)
    else $error("polling past program cycle time");
  no_fight_a: assert property (pins.dq_oe |-> pins.oe_n)
    else $error("data driven while output enable low");

endmodule // fl_flash_host
`default_nettype wire

// ===== tb/fl_flash_model.sv
`default_nettype none
module fl_flash_model #(
  parameter int LOAD_WIN  = 150,
  parameter int PROG_BUSY = 300,
  parameter int PWR_ON    = 20
) (
  // sampling clock and pins
  input  wire logic             clk_i,
  input  wire fl_pkg::fl_pins_t pins_i,
  // data lines
  output logic [7:0]            data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] CA [3] = '{16'h1111, 16'h2222, 16'h3333};
  localparam logic [7:0]  CD [3] = '{8'hA1, 8'hB2, 8'hC3};
  // identity codes, arbitrary values
  localparam logic [7:0]  ID_CODE [2] = '{8'h5C, 8'h6E};
  logic [7:0]   mem [0:65535];
  logic [7:0]   lbuf [0:127];
  logic [127:0] ldd;
  logic [15:0]  lat_a, sec_a;
  logic [7:0]   last_d;
  logic         wr_lo, rd_lo, loading, busy, tgl;
  int           cmd_n, win, bcnt, age;
  wire logic    wr_now = !pins_i.ce_n && !pins_i.we_n && pins_i.oe_n;
  wire logic    rd_now = !pins_i.ce_n && !pins_i.oe_n && pins_i.we_n;

  // power-up contents and state
  initial begin
    for (int a = 0; a < 65536; a++)
      mem[a] = 8'(a) ^ 8'(a >> 8) ^ 8'h5A;
    {wr_lo, rd_lo, loading, busy, tgl} = '0;
    cmd_n = 0;
    win = 0;
    bcnt = 0;
    age = 0;
    ldd = '0;
    data_o = 8'h00;
  end

  // one finished byte write: load, command or stray write
  task automatic take(input logic [15:0] a, input logic [7:0] d);
    if (busy || age < PWR_ON) return;
    if (loading) begin
      if (ldd == '0) sec_a = a;
      lbuf[a[6:0]] = d;
      ldd[a[6:0]] = 1'b1;
      last_d = d;
      win = 0;
    end else if (a == CA[cmd_n] && d == CD[cmd_n]) begin
      cmd_n++;
      loading = (cmd_n == 3);
      ldd = '0;
      win = 0;
    end else begin
      cmd_n = 0;
      last_d = mem[a];
      busy = 1'b1;
      bcnt = PROG_BUSY;
    end
  endtask

  // pins sampled per cycle, so sub-cycle glitches never count
  always @(posedge clk_i) begin
    age++;
    if (wr_now && !wr_lo) lat_a = pins_i.addr;
    if (!wr_now && wr_lo) take(lat_a, pins_i.dq);
    if (loading && !wr_now) win++;
    if (loading && ldd != '0 && win >= LOAD_WIN) begin
      for (int i = 0; i < 128; i++)
        mem[{sec_a[15:7], i[6:0]}] = ldd[i] ? lbuf[i] : 8'hFF;
      loading = 1'b0;
      cmd_n = 0;
      busy = 1'b1;
      bcnt = PROG_BUSY;
    end
    if (busy && bcnt > 0) bcnt--;
    else busy = 1'b0;
    if (rd_now && !rd_lo && busy) tgl = ~tgl;
    if (rd_now)
      data_o <= busy ? {~last_d[7], tgl, last_d[5:0]}
                     : mem[pins_i.addr];
    else
      data_o <= ~data_o;
    wr_lo = wr_now;
    rd_lo = rd_now;
  end
endmodule // fl_flash_model
`default_nettype wire

// ===== tb/fl_flash_host_test.sv
`default_nettype none
module fl_flash_host_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk_i = 1'b0;
  logic             resetn_i = 1'b0;
  logic             start_i = 1'b0;
  logic             wr_valid_i = 1'b0;
  logic [7:0]       wr_data_i = 8'h00;
  fl_pkg::fl_req_t  req_i = '0;
  logic             ready_o, wr_ready_o, rd_valid_o, done_o, err_o;
  logic [7:0]       rd_data_o, data_i;
  fl_pkg::fl_pins_t flash_o;
  int               mismatches = 0;
  int               cmp_count = 0;
  int               cyc = 0;
  logic [7:0]       exp_mem [0:65535];
  logic [8:0]       sec;

  // ---------------------------------------------------------------
  // design, device model, clock
  // ---------------------------------------------------------------
  fl_flash_host #(
    .PROG_CYCLE_CYCLES(2000), .POWER_ON_CYCLES(20), .STARVE_CYCLES(100),
    .WINDOW_CYCLES(200), .LOAD_GAP_CYCLES(150)
  ) i_fl_flash_host (
    .clk_i(clk_i), .resetn_i(resetn_i), .start_i(start_i),
    .req_i(req_i), .ready_o(ready_o), .wr_valid_i(wr_valid_i),
    .wr_data_i(wr_data_i), .wr_ready_o(wr_ready_o),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .done_o(done_o),
    .err_o(err_o), .flash_o(flash_o), .data_i(data_i)
  );

  fl_flash_model i_fl_flash_model (
    .clk_i(clk_i), .pins_i(flash_o), .data_o(data_i)
  );

  always #5 clk_i = ~clk_i;

  // hang limit
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      final_report();
    end
  end

  // strobes never overlap a read, host off the bus while reading
  always @(negedge clk_i) begin
    if (!flash_o.we_n) check({7'h00, flash_o.oe_n}, 8'h01);
    if (!flash_o.oe_n)
      check({6'h00, flash_o.we_n, flash_o.dq_oe}, 8'h02);
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (ready_o !== 1'b1 && n < 5000) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 5000) check(8'h00, 8'h01);
  endtask

  task automatic start_op(input fl_pkg::fl_op_t op, input logic [15:0] a);
    wait_ready();
    start_i = 1'b1;
    req_i = '{op: op, addr: a};
    @(negedge clk_i);
    start_i = 1'b0;
  endtask

  task automatic read_chk(input logic [15:0] a);
    int n;
    start_op(fl_pkg::FL_OP_READ, a);
    for (n = 0; n < 100 && rd_valid_o !== 1'b1; n++) @(negedge clk_i);
    check({7'h00, rd_valid_o}, 8'h01);
    check(rd_data_o, exp_mem[a]);
  endtask

  task automatic prog(input logic [8:0] s, input int nb,
                      output logic [1:0] res);
    int n;
    start_op(fl_pkg::FL_OP_PROG, {s, 7'h00});
    for (int k = 0; k < nb; k++) begin
      for (n = 0; n < 200 && wr_ready_o !== 1'b1; n++) @(negedge clk_i);
      wr_valid_i = 1'b1;
      wr_data_i = 8'($urandom);
      exp_mem[{s, 7'(k)}] = wr_data_i;
      @(negedge clk_i);
      wr_valid_i = 1'b0;
      @(negedge clk_i);
    end
    for (int k = nb; k < 128; k++) exp_mem[{s, 7'(k)}] = 8'hFF;
    for (n = 0; n < 4000 && done_o !== 1'b1 && err_o !== 1'b1; n++)
      @(negedge clk_i);
    res = {done_o, err_o};
    if (done_o) check({7'h00, i_fl_flash_model.busy}, 8'h00);
  endtask

  task automatic sec_chk(input logic [8:0] s);
    read_chk({s, 7'h00});
    read_chk({s, 7'h7F});
    repeat (3) read_chk({s, 7'($urandom)});
    read_chk({s + 9'h001, 7'h00});
  endtask

  task automatic final_report();
    $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [1:0] res;
    for (int a = 0; a < 65536; a++)
      exp_mem[a] = 8'(a) ^ 8'(a >> 8) ^ 8'h5A;
    void'($urandom(27387));
    repeat (4) @(negedge clk_i);
    check({4'h0, flash_o.ce_n, flash_o.oe_n, flash_o.we_n, flash_o.dq_oe},
          8'h0E);
    resetn_i = 1'b1;
    repeat (10) @(negedge clk_i);
    check({7'h00, ready_o}, 8'h00);
    read_chk(16'h0000);
    read_chk(16'hFFFF);
    repeat (8) read_chk(16'($urandom));
    $display("test reads done");
    sec = 9'($urandom);
    prog(sec, 128, res);
    check({6'h00, res}, 8'h02);
    sec_chk(sec);
    $display("test full sector done");
    prog(sec, 128, res);
    check({6'h00, res}, 8'h02);
    sec_chk(sec);
    $display("test reprogram done");
    sec = sec + 9'h009;
    prog(sec, 7, res);
    check({6'h00, res}, 8'h01);
    sec_chk(sec);
    $display("test partial sector done");
    start_op(fl_pkg::FL_OP_READ, 16'h0040);
    @(negedge clk_i);
    start_i = 1'b1;
    req_i = '{op: fl_pkg::FL_OP_PROG, addr: 16'h0080};
    @(negedge clk_i);
    start_i = 1'b0;
    wait_ready();
    repeat (20) @(negedge clk_i);
    check({6'h00, ready_o, wr_ready_o}, 8'h02);
    $display("test refused start done");
    final_report();
  end
endmodule // fl_flash_host_test
`default_nettype wire
